// ==== logic/slt_pkg.sv ====
package slt_pkg;

  // Read command families, also the column index of the latency tables
  typedef enum logic [2:0]
  {
    SLT_FAM_READ = 3'h0,
    SLT_FAM_FAST = 3'h1,
    SLT_FAM_DOUT = 3'h2,
    SLT_FAM_QOUT = 3'h3,
    SLT_FAM_DIO  = 3'h4,
    SLT_FAM_QIO  = 3'h5
  } slt_fam_t;

  typedef enum logic [2:0]
  {
    SLT_ST_IDLE = 3'h0,
    SLT_ST_CMD  = 3'h1,
    SLT_ST_ADDR = 3'h2,
    SLT_ST_MODE = 3'h3,
    SLT_ST_LAT  = 3'h4,
    SLT_ST_DATA = 3'h5,
    SLT_ST_SKIP = 3'h6
  } slt_state_t;

  localparam int SLT_NUM_ROW = 5;
  localparam int SLT_NUM_FAM = 6;

  localparam logic [7:0] SLT_UNSUPPORTED = 8'hFF;
  localparam logic [7:0] SLT_ZERO_CYC    = 8'h00;

  // Latency codes and the table rows they select
  localparam logic [1:0] SLT_LC_50  = 2'h3;
  localparam logic [1:0] SLT_LC_80  = 2'h0;
  localparam logic [1:0] SLT_LC_90  = 2'h1;
  localparam logic [1:0] SLT_LC_104 = 2'h2;

  localparam logic [2:0] SLT_ROW_50  = 3'h0;
  localparam logic [2:0] SLT_ROW_80  = 3'h1;
  localparam logic [2:0] SLT_ROW_90  = 3'h2;
  localparam logic [2:0] SLT_ROW_104 = 3'h3;
  localparam logic [2:0] SLT_ROW_133 = 3'h4;

  // Columns: read, fast, dual out, quad out, dual I/O, quad I/O
  // Rows 50, 80, 90, 104, 133 MHz
  localparam logic [7:0] SLT_MODE_TBL [0:SLT_NUM_ROW-1][0:SLT_NUM_FAM-1] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF}
  };
  localparam logic [7:0] SLT_LAT_TBL [0:SLT_NUM_ROW-1][0:SLT_NUM_FAM-1] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01},
    '{8'hFF, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04},
    '{8'hFF, 8'h08, 8'h08, 8'h08, 8'h05, 8'h04},
    '{8'hFF, 8'h08, 8'h08, 8'h08, 8'h06, 8'h05},
    '{8'hFF, 8'h08, 8'hFF, 8'hFF, 8'hFF, 8'hFF}
  };

  // Opcodes, three-byte and four-byte address forms
  localparam logic [7:0] SLT_OP_READ3 = 8'h03;
  localparam logic [7:0] SLT_OP_READ4 = 8'h13;
  localparam logic [7:0] SLT_OP_FAST3 = 8'h0B;
  localparam logic [7:0] SLT_OP_FAST4 = 8'h0C;
  localparam logic [7:0] SLT_OP_DOUT3 = 8'h3B;
  localparam logic [7:0] SLT_OP_DOUT4 = 8'h3C;
  localparam logic [7:0] SLT_OP_QOUT3 = 8'h6B;
  localparam logic [7:0] SLT_OP_QOUT4 = 8'h6C;
  localparam logic [7:0] SLT_OP_DIO3  = 8'hBB;
  localparam logic [7:0] SLT_OP_DIO4  = 8'hBC;
  localparam logic [7:0] SLT_OP_QIO3  = 8'hEB;
  localparam logic [7:0] SLT_OP_QIO4  = 8'hEC;

  localparam logic [7:0] SLT_CMD_CYC   = 8'h08;
  localparam logic [7:0] SLT_ADDR3_CYC = 8'h18;
  localparam logic [7:0] SLT_ADDR4_CYC = 8'h20;

  // Lane width as log2 of bits per serial clock
  localparam logic [1:0] SLT_LG_X1 = 2'h0;
  localparam logic [1:0] SLT_LG_X2 = 2'h1;
  localparam logic [1:0] SLT_LG_X4 = 2'h2;

  localparam logic [3:0] SLT_OE_X1 = 4'h2;
  localparam logic [3:0] SLT_OE_X2 = 4'h3;
  localparam logic [3:0] SLT_OE_X4 = 4'hF;
  localparam logic [2:0] SLT_BIT_ONE = 3'h1;

endpackage

// ==== logic/slt_latency_table.sv ====
`timescale 1ns/100ps
module slt_latency_table
  import slt_pkg::*;
(
  input  wire logic [1:0] latency_code_in,
  input  wire logic       band_133_in,
  input  wire slt_fam_t   fam_in,
  output logic      [7:0] mode_cyc_out,
  output logic      [7:0] lat_cyc_out,
  output logic            supported_out
);

  // Code 10b is shared by two bands; only the strap tells them apart
  function automatic logic [2:0] row_of(input logic [1:0] lc, input logic hi);
    case (lc)
      SLT_LC_50: row_of = SLT_ROW_50;
      SLT_LC_80: row_of = SLT_ROW_80;
      SLT_LC_90: row_of = SLT_ROW_90;
      default:   row_of = hi ? SLT_ROW_133 : SLT_ROW_104;
    endcase
  endfunction

  wire logic [2:0] row_w = row_of(latency_code_in, band_133_in);

  assign mode_cyc_out  = SLT_MODE_TBL[row_w][fam_in];
  assign lat_cyc_out   = SLT_LAT_TBL[row_w][fam_in];
  assign supported_out = (mode_cyc_out != SLT_UNSUPPORTED) && (lat_cyc_out != SLT_UNSUPPORTED);

endmodule

// ==== logic/slt_read_seq.sv ====
`timescale 1ns/100ps
module slt_read_seq
  import slt_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic  [3:0] io_in,
  input  wire logic  [1:0] latency_code_in,
  input  wire logic        band_133_in,
  input  wire logic  [7:0] rd_data_in,
  output logic       [3:0] io_out,
  output logic       [3:0] io_oe_out,
  output logic      [31:0] rd_addr_out,
  output logic       [7:0] mode_bits_out,
  output logic             reject_out,
  output logic             busy_out
);

  // {valid, four_byte, family}
  function automatic logic [4:0] decode_cmd(input logic [7:0] op);
    case (op)
      SLT_OP_READ3: decode_cmd = {2'h2, SLT_FAM_READ};
      SLT_OP_READ4: decode_cmd = {2'h3, SLT_FAM_READ};
      SLT_OP_FAST3: decode_cmd = {2'h2, SLT_FAM_FAST};
      SLT_OP_FAST4: decode_cmd = {2'h3, SLT_FAM_FAST};
      SLT_OP_DOUT3: decode_cmd = {2'h2, SLT_FAM_DOUT};
      SLT_OP_DOUT4: decode_cmd = {2'h3, SLT_FAM_DOUT};
      SLT_OP_QOUT3: decode_cmd = {2'h2, SLT_FAM_QOUT};
      SLT_OP_QOUT4: decode_cmd = {2'h3, SLT_FAM_QOUT};
      SLT_OP_DIO3:  decode_cmd = {2'h2, SLT_FAM_DIO};
      SLT_OP_DIO4:  decode_cmd = {2'h3, SLT_FAM_DIO};
      SLT_OP_QIO3:  decode_cmd = {2'h2, SLT_FAM_QIO};
      SLT_OP_QIO4:  decode_cmd = {2'h3, SLT_FAM_QIO};
      default:      decode_cmd = {2'h0, SLT_FAM_READ};
    endcase
  endfunction

  // {address lanes, data lanes} as log2 widths
  function automatic logic [3:0] lanes_of(input slt_fam_t f);
    case (f)
      SLT_FAM_DOUT: lanes_of = {SLT_LG_X1, SLT_LG_X2};
      SLT_FAM_QOUT: lanes_of = {SLT_LG_X1, SLT_LG_X4};
      SLT_FAM_DIO:  lanes_of = {SLT_LG_X2, SLT_LG_X2};
      SLT_FAM_QIO:  lanes_of = {SLT_LG_X4, SLT_LG_X4};
      default:      lanes_of = {SLT_LG_X1, SLT_LG_X1};
    endcase
  endfunction

  function automatic logic [31:0] shift_in(input logic [31:0] v, input logic [3:0] io,
                                           input logic [1:0] lg);
    case (lg)
      SLT_LG_X1: shift_in = {v[30:0], io[0]};
      SLT_LG_X2: shift_in = {v[29:0], io[1:0]};
      default:   shift_in = {v[27:0], io};
    endcase
  endfunction

  // Pin synchronisers: first stage feeds only the second
  logic [5:0]  sync1_q;
  logic [5:0]  sync2_q;
  logic        sck_last_q;
  slt_state_t  state_q;
  slt_state_t  state_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cmd_sh_q;
  slt_fam_t    fam_q;
  logic        four_q;
  logic [31:0] addr_q;
  logic [7:0]  mode_q;
  logic [7:0]  data_sh_q;
  logic [2:0]  bcnt_q;
  logic [3:0]  io_q;
  logic [3:0]  oe_q;
  logic        reject_q;

  wire logic       sck_s    = sync2_q[5];
  wire logic       cs_n_s   = sync2_q[4];
  wire logic [3:0] io_s     = sync2_q[3:0];
  wire logic       sck_rise = sck_s & ~sck_last_q;
  wire logic       sck_fall = ~sck_s & sck_last_q;

  wire logic [7:0] op_w     = {cmd_sh_q[6:0], io_s[0]};
  wire logic [4:0] dec_w    = decode_cmd(op_w);
  wire logic       dec_ok_w = dec_w[4];
  wire slt_fam_t   dec_fam  = slt_fam_t'(dec_w[2:0]);
  wire slt_fam_t   fam_sel  = (state_q == SLT_ST_CMD) ? dec_fam : fam_q;
  wire logic [3:0] lanes_w  = lanes_of(fam_q);
  wire logic [1:0] alg_w    = lanes_w[3:2];
  wire logic [1:0] dlg_w    = lanes_w[1:0];

  logic [7:0] tbl_mode;
  logic [7:0] tbl_lat;
  logic       tbl_ok;

  slt_latency_table u_table
  (
    .latency_code_in (latency_code_in),
    .band_133_in     (band_133_in),
    .fam_in          (fam_sel),
    .mode_cyc_out    (tbl_mode),
    .lat_cyc_out     (tbl_lat),
    .supported_out   (tbl_ok)
  );

  wire logic [7:0] cnt_inc   = cnt_q + 8'h01;
  wire logic [7:0] addr_cyc  = (four_q ? SLT_ADDR4_CYC : SLT_ADDR3_CYC) >> alg_w;
  wire logic       cmd_last  = (cnt_inc == SLT_CMD_CYC);
  wire logic       addr_last = (cnt_inc == addr_cyc);
  wire logic       mode_last = (cnt_inc == tbl_mode);
  wire logic       lat_last  = (cnt_inc == tbl_lat);
  // Unknown opcodes and all-ones table entries are both refused
  wire logic       cmd_ok    = dec_ok_w && tbl_ok;

  // Zero-length phases are skipped so data follows at once
  wire slt_state_t after_mode_st = (tbl_lat != SLT_ZERO_CYC) ? SLT_ST_LAT : SLT_ST_DATA;
  wire slt_state_t after_addr_st = (tbl_mode != SLT_ZERO_CYC) ? SLT_ST_MODE : after_mode_st;

  // Mode bits shift at the address lane width
  wire logic [31:0] mode_sh_w = shift_in({24'h0, mode_q}, io_s, alg_w);

  // Data path: a fresh byte is taken from the array at lane offset zero
  wire logic [2:0] step_w     = SLT_BIT_ONE << dlg_w;
  wire logic [7:0] cur_byte_w = (bcnt_q == 3'h0) ? rd_data_in : data_sh_q;
  wire logic [3:0] io_nxt_w   = (dlg_w == SLT_LG_X4) ? cur_byte_w[7:4] :
                                (dlg_w == SLT_LG_X2) ? {2'h0, cur_byte_w[7:6]} :
                                {2'h0, cur_byte_w[7], 1'b0};
  wire logic [3:0] oe_pat_w   = (dlg_w == SLT_LG_X4) ? SLT_OE_X4 :
                                (dlg_w == SLT_LG_X2) ? SLT_OE_X2 : SLT_OE_X1;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SLT_ST_IDLE: if (!cs_n_s) state_d = SLT_ST_CMD;
      SLT_ST_CMD:  if (sck_rise && cmd_last) state_d = cmd_ok ? SLT_ST_ADDR : SLT_ST_SKIP;
      SLT_ST_ADDR: if (sck_rise && addr_last) state_d = after_addr_st;
      SLT_ST_MODE: if (sck_rise && mode_last) state_d = after_mode_st;
      SLT_ST_LAT:  if (sck_rise && lat_last) state_d = SLT_ST_DATA;
      SLT_ST_DATA: state_d = SLT_ST_DATA;
      SLT_ST_SKIP: state_d = SLT_ST_SKIP;
      default:     state_d = SLT_ST_IDLE;
    endcase
    if (cs_n_s)
      state_d = SLT_ST_IDLE;
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sync1_q    <= 6'h10;
      sync2_q    <= 6'h10;
      sck_last_q <= 1'b0;
      state_q    <= SLT_ST_IDLE;
      cnt_q      <= 8'h00;
      reject_q   <= 1'b0;
    end
    else
    begin
      sync1_q    <= {sck_in, cs_n_in, io_in};
      sync2_q    <= sync1_q;
      sck_last_q <= sck_s;
      state_q    <= state_d;
      cnt_q      <= (state_d != state_q) ? 8'h00 : (sck_rise ? cnt_inc : cnt_q);
      reject_q   <= (state_q == SLT_ST_CMD) && (state_d == SLT_ST_SKIP);
    end
  end

  // Command, address and mode capture on rising serial clock edges
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cmd_sh_q <= 8'h00;
      fam_q    <= SLT_FAM_READ;
      four_q   <= 1'b0;
      mode_q   <= 8'h00;
    end
    else if (sck_rise)
    begin
      if (state_q == SLT_ST_CMD)
        cmd_sh_q <= op_w;
      if (state_q == SLT_ST_CMD && cmd_last)
      begin
        fam_q  <= dec_fam;
        four_q <= dec_w[3];
      end
      if (state_q == SLT_ST_MODE)
        mode_q <= mode_sh_w[7:0];
    end
  end

  // Address register doubles as the byte pointer during data
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      addr_q <= 32'h0;
    else if (state_q == SLT_ST_IDLE)
      addr_q <= 32'h0;
    else if (state_q == SLT_ST_ADDR && sck_rise)
      addr_q <= shift_in(addr_q, io_s, alg_w);
    else if (state_q == SLT_ST_DATA && sck_fall && bcnt_q == 3'h0)
      addr_q <= addr_q + 32'h1;
  end

  // Output lanes change on falling edges so the host samples on rising ones
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      data_sh_q <= 8'h00;
      bcnt_q    <= 3'h0;
      io_q      <= 4'h0;
      oe_q      <= 4'h0;
    end
    else if (state_d != SLT_ST_DATA)
    begin
      bcnt_q <= 3'h0;
      oe_q   <= 4'h0;
    end
    else if (state_q == SLT_ST_DATA && sck_fall)
    begin
      data_sh_q <= cur_byte_w << step_w;
      bcnt_q    <= bcnt_q + step_w;
      io_q      <= io_nxt_w;
      oe_q      <= oe_pat_w;
    end
  end

  assign io_out        = io_q;
  assign io_oe_out     = oe_q;
  assign rd_addr_out   = addr_q;
  assign mode_bits_out = mode_q;
  assign reject_out    = reject_q;
  assign busy_out      = (state_q != SLT_ST_IDLE);

  default clocking cb_sys @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  wire logic in_tail = (state_q == SLT_ST_ADDR) || (state_q == SLT_ST_MODE) ||
                       (state_q == SLT_ST_LAT);

  sequence s_cmd_done;
    (state_q == SLT_ST_CMD) && sck_rise && cmd_last && !cs_n_s;
  endsequence
  sequence s_addr_done;
    (state_q == SLT_ST_ADDR) && sck_rise && addr_last && !cs_n_s;
  endsequence
  sequence s_lat_done;
    (state_q == SLT_ST_LAT) && sck_rise && lat_last && !cs_n_s;
  endsequence

  property p_basic_refused;
    s_cmd_done ##0 (dec_ok_w && dec_fam == SLT_FAM_READ && latency_code_in != SLT_LC_50)
      |=> (state_q == SLT_ST_SKIP) && reject_out;
  endproperty
  a_basic_refused: assert property (p_basic_refused) else $error("basic read not refused");

  property p_band50_basic_ok;
    s_cmd_done ##0 (dec_ok_w && dec_fam == SLT_FAM_READ && latency_code_in == SLT_LC_50)
      |=> (state_q == SLT_ST_ADDR) && !reject_out;
  endproperty
  a_band50_basic_ok: assert property (p_band50_basic_ok) else $error("50 MHz read refused");

  property p_133_only_fast;
    s_cmd_done ##0 (dec_ok_w && dec_fam != SLT_FAM_FAST && latency_code_in == SLT_LC_104
                    && band_133_in) |=> (state_q == SLT_ST_SKIP) ##1 (io_oe_out == 4'h0);
  endproperty
  a_133_only_fast: assert property (p_133_only_fast) else $error("133 MHz multi-bit read taken");

  property p_band50_plain;
    s_addr_done ##0 (latency_code_in == SLT_LC_50 && fam_q <= SLT_FAM_QOUT)
      |=> (state_q == SLT_ST_DATA);
  endproperty
  a_band50_plain: assert property (p_band50_plain) else $error("50 MHz plain read delayed");

  property p_band50_io;
    (in_tail && latency_code_in == SLT_LC_50 && fam_q == SLT_FAM_QIO)
      |-> (tbl_mode == 8'h02 && tbl_lat == 8'h01);
  endproperty
  a_band50_io: assert property (p_band50_io) else $error("50 MHz quad I/O cycles wrong");

  property p_band80_out;
    (in_tail && latency_code_in == SLT_LC_80 && fam_q != SLT_FAM_DIO && fam_q != SLT_FAM_QIO)
      |-> (tbl_mode == 8'h00 && tbl_lat == 8'h08);
  endproperty
  a_band80_out: assert property (p_band80_out) else $error("80 MHz read cycles wrong");

  property p_band80_qio;
    (in_tail && latency_code_in == SLT_LC_80 && fam_q == SLT_FAM_QIO)
      |-> (tbl_mode == 8'h02 && tbl_lat == 8'h04);
  endproperty
  a_band80_qio: assert property (p_band80_qio) else $error("80 MHz quad I/O cycles wrong");

  property p_band90_dio;
    (in_tail && latency_code_in == SLT_LC_90 && fam_q == SLT_FAM_DIO)
      |-> (tbl_mode == 8'h00 && tbl_lat == 8'h05);
  endproperty
  a_band90_dio: assert property (p_band90_dio) else $error("90 MHz dual I/O cycles wrong");

  property p_band104_qio;
    (in_tail && latency_code_in == SLT_LC_104 && !band_133_in && fam_q == SLT_FAM_QIO)
      |-> (tbl_mode == 8'h02 && tbl_lat == 8'h05);
  endproperty
  a_band104_qio: assert property (p_band104_qio) else $error("104 MHz quad I/O cycles wrong");

  property p_data_after_lat;
    s_lat_done |=> (state_q == SLT_ST_DATA) && (io_oe_out == 4'h0);
  endproperty
  a_data_after_lat: assert property (p_data_after_lat) else $error("data not after latency");

  property p_drive_only_data;
    (io_oe_out != 4'h0) |-> (state_q == SLT_ST_DATA) && !$past(cs_n_s);
  endproperty
  a_drive_only_data: assert property (p_drive_only_data) else $error("lanes driven early");

endmodule

// ==== testbench/slt_host_model.sv ====
`timescale 1ns/100ps
module slt_host_model
(
  input  wire logic        clk_sys_in,
  input  wire logic  [3:0] io_out,
  input  wire logic  [3:0] io_oe_out,
  input  wire logic [31:0] rd_addr_out,
  output logic             sck_in,
  output logic             cs_n_in,
  output logic       [3:0] io_in,
  output logic       [7:0] rd_data_in
);
  logic [3:0] hv = 4'h0;
  logic       drv = 1'b0;
  logic       watch = 1'b0;
  logic       early = 1'b0;
  logic       oe_any = 1'b0;
  logic [3:0] samp;

  initial
  begin
    sck_in = 1'b0;
    cs_n_in = 1'b1;
    rd_data_in = 8'h00;
  end

  // Released lanes show the inverse of the last value so stale bits cannot pass
  assign io_in = (io_oe_out & io_out) | (~io_oe_out & (drv ? hv : ~hv));

  // Array stand-in: byte depends on address, valid one clock later
  always @(posedge clk_sys_in)
    rd_data_in <= rd_addr_out[7:0] ^ 8'h5A;

  always @(posedge clk_sys_in)
  begin
    if (!cs_n_in && io_oe_out !== 4'h0)
    begin
      oe_any <= 1'b1;
      if (watch)
        early <= 1'b1;
    end
  end

  function automatic logic [3:0] lmask(input int lg);
    return 4'((1 << (1 << lg)) - 1);
  endfunction

  // One 80 ns serial clock; lanes are sampled just before the rise
  task automatic tick();
    repeat (5) @(negedge clk_sys_in);
    samp = io_in;
    sck_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    sck_in = 1'b0;
  endtask

  task automatic send(input logic [31:0] v, input int nbits, input int lg);
    for (int i = nbits - (1 << lg); i >= 0; i -= (1 << lg))
    begin
      hv = 4'(v >> i) & lmask(lg);
      tick();
    end
  endtask

  task automatic read_frame(input logic [7:0] op, input logic [31:0] adr, input int abits,
                            input int alg, input int mcyc, input int lcyc, input int dlg,
                            output logic [15:0] dat);
    early = 1'b0;
    oe_any = 1'b0;
    dat = 16'h0000;
    drv = 1'b1;
    watch = 1'b1;
    cs_n_in = 1'b0;
    send(32'(op), 8, 0);
    send(adr, abits, alg);
    send(32'hA5, mcyc << alg, alg);
    drv = 1'b0;
    repeat (lcyc) tick();
    watch = 1'b0;
    repeat (16 >> dlg)
    begin
      tick();
      dat = (dat << (1 << dlg)) | 16'((dlg == 0) ? {3'h0, samp[1]} : (samp & lmask(dlg)));
    end
    cs_n_in = 1'b1;
    repeat (12) @(negedge clk_sys_in);
  endtask
endmodule

// ==== testbench/tb_sdr_read_latency_table.sv ====
`timescale 1ns/100ps
module tb_sdr_read_latency_table;
  import slt_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        reset_in = 1'b1;
  logic  [1:0] code = 2'h3;
  logic        band_133 = 1'b0;
  logic        sck;
  logic        cs_n;
  logic  [3:0] io_in;
  logic  [3:0] io_out;
  logic  [3:0] io_oe;
  logic  [7:0] rd_data;
  logic  [7:0] mode_bits;
  logic [31:0] rd_addr;
  logic        reject;
  logic        busy;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          rej_cnt = 0;

  always #4 clk_sys_in = ~clk_sys_in;

  always @(negedge clk_sys_in)
    if (reject === 1'b1)
      rej_cnt++;

  slt_read_seq DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .sck_in(sck),
    .cs_n_in(cs_n), .io_in(io_in), .latency_code_in(code), .band_133_in(band_133),
    .rd_data_in(rd_data), .io_out(io_out), .io_oe_out(io_oe), .rd_addr_out(rd_addr),
    .mode_bits_out(mode_bits), .reject_out(reject), .busy_out(busy));

  slt_host_model host (.clk_sys_in(clk_sys_in), .io_out(io_out), .io_oe_out(io_oe),
    .rd_addr_out(rd_addr), .sck_in(sck), .cs_n_in(cs_n), .io_in(io_in),
    .rd_data_in(rd_data));

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A refused command must pulse reject once and never drive a lane
  task automatic rd(input logic [7:0] op, input int mcyc, input int lcyc, input logic ok);
    logic [15:0] d;
    int          r0;
    int          alg;
    int          dlg;
    r0 = rej_cnt;
    alg = (op[7:4] == 4'hB) ? 1 : (op[7:4] == 4'hE) ? 2 : 0;
    dlg = (op[7:4] == 4'h3 || alg == 1) ? 1 : (op[7:4] == 4'h6 || alg == 2) ? 2 : 0;
    host.read_frame(op, 32'h12AB_CD3C, (op[2] || op == 8'h13) ? 32 : 24, alg, mcyc, lcyc,
                    dlg, d);
    chk_flag(host.early, 1'b0);
    if (ok)
    begin
      chk_val(d, {8'h3C ^ 8'h5A, 8'h3D ^ 8'h5A});
      chk_val(16'(rej_cnt - r0), 16'h0000);
      if (mcyc != 0)
        chk_val({8'h00, mode_bits}, 16'h00A5);
    end
    else
    begin
      chk_val(16'(rej_cnt - r0), 16'h0001);
      chk_flag(host.oe_any, 1'b0);
    end
    chk_flag(busy, 1'b0);
  endtask

  task automatic t_band50();
    code = 2'h3;
    band_133 = 1'b0;
    rd(8'h03, 0, 0, 1'b1);
    rd(8'h0B, 0, 0, 1'b1);
    rd(8'h3B, 0, 0, 1'b1);
    rd(8'h6C, 0, 0, 1'b1);
    rd(8'hBB, 0, 4, 1'b1);
    rd(8'hEB, 2, 1, 1'b1);
    $display("test band50 done");
  endtask

  task automatic t_band80();
    code = 2'h0;
    rd(8'h13, 0, 0, 1'b0);
    rd(8'h0C, 0, 8, 1'b1);
    rd(8'h3C, 0, 8, 1'b1);
    rd(8'h6B, 0, 8, 1'b1);
    rd(8'hBC, 0, 4, 1'b1);
    rd(8'hEC, 2, 4, 1'b1);
    $display("test band80 done");
  endtask

  task automatic t_band90();
    code = 2'h1;
    rd(8'h03, 0, 0, 1'b0);
    rd(8'h0B, 0, 8, 1'b1);
    rd(8'h3C, 0, 8, 1'b1);
    rd(8'h6B, 0, 8, 1'b1);
    rd(8'hBB, 0, 5, 1'b1);
    rd(8'hEB, 2, 4, 1'b1);
    $display("test band90 done");
  endtask

  task automatic t_band104();
    code = 2'h2;
    band_133 = 1'b0;
    rd(8'h13, 0, 0, 1'b0);
    rd(8'h0C, 0, 8, 1'b1);
    rd(8'h3B, 0, 8, 1'b1);
    rd(8'h6C, 0, 8, 1'b1);
    rd(8'hBC, 0, 6, 1'b1);
    rd(8'hEC, 2, 5, 1'b1);
    $display("test band104 done");
  endtask

  task automatic t_band133();
    code = 2'h2;
    band_133 = 1'b1;
    rd(8'h0B, 0, 8, 1'b1);
    rd(8'h03, 0, 0, 1'b0);
    rd(8'h3B, 0, 0, 1'b0);
    rd(8'h6C, 0, 0, 1'b0);
    rd(8'hBB, 0, 0, 1'b0);
    rd(8'hEC, 0, 0, 1'b0);
    rd(8'h9F, 0, 0, 1'b0);
    $display("test band133 done");
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge clk_sys_in);
    chk_val({12'h000, io_oe}, 16'h0000);
    reset_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    chk_flag(busy, 1'b0);
    t_band50();
    t_band80();
    t_band90();
    t_band104();
    t_band133();
    final_report();
  end

  // About 31 frames of 3.6 us each; three times that is a hang
  initial
  begin
    #350000;
    miscompares++;
    final_report();
  end
endmodule
